/* File: design/actc_pkg.sv */
package actc_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_DIS_LOW  = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_CTRL_B   = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_DIS_HIGH = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_CTRL_A   = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h9;

  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [7:0] CTRL_B_WMASK = 8'hDF;
  localparam logic [7:0] DIS_HIGH_WMASK = 8'hF0;
  localparam logic [7:0] CTRL_A_WMASK = 8'hA0;

  localparam int unsigned B_BIP   = 7;
  localparam int unsigned B_GAIN_UPPER_SELECT  = 6;
  localparam int unsigned B_REFH  = 4;
  localparam int unsigned B_MSB   = 3;
  localparam int unsigned B_ENA   = 7;
  localparam int unsigned B_ATE   = 5;
  localparam int unsigned B_DONE  = 4;
  localparam int unsigned B_REFPIN = 3;

  localparam int unsigned NUM_PINS = 12;
  localparam int unsigned RES_UNI  = 10;
  localparam int unsigned RES_BIP_MAG = 9;

  // Interrupt status bits
  localparam int unsigned EV_TRIG = 0;
  localparam int unsigned EV_DONE = 1;

  typedef enum logic [2:0] {
    TRG_FREE  = 3'h0,
    TRG_ACOMP = 3'h1,
    TRG_EXT0  = 3'h2,
    TRG_T0CA  = 3'h3,
    TRG_T0OV  = 3'h4,
    TRG_T0CB  = 3'h5,
    TRG_T1OV  = 3'h6,
    TRG_WDOG  = 3'h7
  } actc_trig_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01
  } actc_state_type;

  typedef struct packed {
    logic       bipolar_input_select;
    logic       gain_upper_select;
    logic       reference_select_high;
    logic       channel_select_msb;
    logic [1:0] gain_code;
  } actc_core_cfg_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } actc_bus_type;
endpackage

/* File: design/actc_trig_edge.sv */
`timescale 1ns/1ps
module actc_trig_edge
  import actc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] flags,
  input  wire logic [2:0] sel,
  input  wire logic       arm,
  output logic            edge_pulse
);
  logic cur_level;
  logic prev_level_r;

  // Free running has no flag of its own, so it never yields an edge
  assign cur_level = (sel == TRG_FREE) ? 1'b0 : flags[sel];

  // Compare against the last selected level, so a source switch
  // from clear to set also registers as an edge
  assign edge_pulse = arm & cur_level & ~prev_level_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_level_r <= 1'b0;
    end else begin
      prev_level_r <= cur_level;
    end
  end
endmodule

/* File: design/actc_top.sv */
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module actc_top
  import actc_pkg::*;
(
  input  wire logic                      SYS_CLK,
  input  wire logic                      SYS_RST,
  input  wire logic [actc_pkg::ADDR_W-1:0] BUS_ADDR,
  input  wire logic [7:0]                BUS_WDATA,
  input  wire logic                      BUS_WR,
  input  wire logic                      BUS_RD,
  output logic [7:0]                     BUS_RDATA,
  input  wire logic [7:0]                TRIG_FLAGS,
  input  wire logic                      CONV_DONE,
  input  wire logic                      DONE_VECTOR_ACK,
  input  wire logic [actc_pkg::NUM_PINS-1:0] PIN_RAW,
  output logic [actc_pkg::NUM_PINS-1:0]  PIN_READ,
  output logic [actc_pkg::NUM_PINS-1:0]  PIN_BUF_DISABLE,
  output logic                           CONV_START,
  output logic                           CONV_BUSY,
  output actc_pkg::actc_core_cfg_type    CORE_CFG,
  output logic                           CONV_DONE_IRQ,
  output logic                           IRQ
);
  import actc_pkg::*;

  actc_bus_type   bus;
  actc_state_type state_r;
  actc_state_type state_nxt;

  logic [7:0] ctrl_b_r;
  logic [7:0] dis_low_r;
  logic [7:0] dis_high_r;
  logic [7:0] ctrl_a_r;
  logic [7:0] irq_stat_r;
  logic [7:0] irq_mask_r;
  logic [7:0] rdata_r;
  logic       done_flag_r;
  logic       start_r;

  logic [NUM_PINS-1:0] pin_s1_r;
  logic [NUM_PINS-1:0] pin_s2_r;
  logic [7:0]          trig_s1_r;
  logic [7:0]          trig_s2_r;

  actc_core_cfg_type cfg_live;
  actc_core_cfg_type cfg_r;

  assign bus = '{addr: BUS_ADDR, wdata: BUS_WDATA, wr: BUS_WR, rd: BUS_RD};

  logic wr_ctrl_b;
  logic wr_dis_low;
  logic wr_dis_high;
  logic wr_ctrl_a;
  logic wr_stat;
  logic wr_mask;
  assign wr_ctrl_b   = bus.wr & (bus.addr == OFS_CTRL_B);
  assign wr_dis_low  = bus.wr & (bus.addr == OFS_DIS_LOW);
  assign wr_dis_high = bus.wr & (bus.addr == OFS_DIS_HIGH);
  assign wr_ctrl_a   = bus.wr & (bus.addr == OFS_CTRL_A);
  assign wr_stat     = bus.wr & (bus.addr == OFS_IRQ_STAT);
  assign wr_mask     = bus.wr & (bus.addr == OFS_IRQ_MASK);

  logic conv_ena;
  logic auto_ena;
  assign conv_ena = ctrl_a_r[B_ENA];
  assign auto_ena = ctrl_a_r[B_ATE];

  // Trigger edge detect
  logic trig_edge;
  actc_trig_edge u_edge (
    .clk        (SYS_CLK),
    .rst        (SYS_RST),
    .flags      (trig_s2_r),
    .sel        (ctrl_b_r[2:0]),
    .arm        (auto_ena & conv_ena),
    .edge_pulse (trig_edge)
  );

  logic start_req;
  assign start_req = trig_edge & (state_r == ST_IDLE);

  // Conversion tracking, so channel MSB is only applied between conversions
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (start_req) begin
          state_nxt = ST_CONV;
        end
      end
      ST_CONV: begin
        if (CONV_DONE | ~conv_ena) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  // Gain code: bit 1 (high gain pair) tied low, bit 0 upper gain
  // 00 = 1x, 01 = 8x, 10 = 20x, 11 = 32x; core picks pair from channel code
  assign cfg_live.bipolar_input_select  = ctrl_b_r[B_BIP];
  assign cfg_live.gain_upper_select     = ctrl_b_r[B_GAIN_UPPER_SELECT];
  assign cfg_live.reference_select_high = ctrl_b_r[B_REFH];
  assign cfg_live.channel_select_msb    = cfg_r.channel_select_msb;
  assign cfg_live.gain_code = {1'b0, ctrl_b_r[B_GAIN_UPPER_SELECT]};

  logic msb_update;
  assign msb_update = (state_r == ST_IDLE) | CONV_DONE;

  logic [7:0] stat_set;
  always_comb begin
    stat_set = RST_BYTE;
    stat_set[EV_TRIG] = start_req;
    stat_set[EV_DONE] = CONV_DONE;
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_r <= ST_IDLE;
      start_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      start_r <= start_req;
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl_b_r <= RST_BYTE;
    end else if (wr_ctrl_b) begin
      ctrl_b_r <= bus.wdata & CTRL_B_WMASK;
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cfg_r <= '0;
    end else if (msb_update) begin
      cfg_r.channel_select_msb <= ctrl_b_r[B_MSB];
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      dis_low_r  <= RST_BYTE;
      dis_high_r <= RST_BYTE;
    end else begin
      if (wr_dis_low) begin
        dis_low_r <= bus.wdata;
      end
      if (wr_dis_high) begin
        dis_high_r <= bus.wdata & DIS_HIGH_WMASK;
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl_a_r <= RST_BYTE;
    end else if (wr_ctrl_a) begin
      ctrl_a_r <= bus.wdata & CTRL_A_WMASK;
    end
  end

  // Set wins over a same-cycle clear
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      done_flag_r <= 1'b0;
    end else begin
      done_flag_r <= CONV_DONE |
        (done_flag_r & ~DONE_VECTOR_ACK &
         ~(wr_ctrl_a & bus.wdata[B_DONE]));
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_stat_r <= RST_BYTE;
      irq_mask_r <= RST_BYTE;
    end else begin
      irq_stat_r <= stat_set |
        (irq_stat_r & ~({8{wr_stat}} & bus.wdata));
      if (wr_mask) begin
        irq_mask_r <= bus.wdata;
      end
    end
  end

  // Pins come from outside the clock domain
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pin_s1_r  <= '0;
      pin_s2_r  <= '0;
      trig_s1_r <= RST_BYTE;
      trig_s2_r <= RST_BYTE;
    end else begin
      pin_s1_r  <= PIN_RAW;
      pin_s2_r  <= pin_s1_r;
      trig_s1_r <= TRIG_FLAGS;
      trig_s2_r <= trig_s1_r;
    end
  end

  // Pin order: [6:0] analogue 6..0, [7] reference pin, [11:8] analogue 10..7
  logic [NUM_PINS-1:0] dis_vec;
  assign dis_vec = {dis_high_r[7:4], dis_low_r[B_REFPIN],
                    dis_low_r[7:4], dis_low_r[2:0]};

  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = RST_BYTE;
    unique case (bus.addr)
      OFS_CTRL_B:   rd_mux = ctrl_b_r & CTRL_B_WMASK;
      OFS_DIS_LOW:  rd_mux = dis_low_r;
      OFS_DIS_HIGH: rd_mux = dis_high_r;
      OFS_CTRL_A: begin
        rd_mux = ctrl_a_r;
        rd_mux[B_DONE] = done_flag_r;
      end
      OFS_IRQ_STAT: rd_mux = irq_stat_r;
      OFS_IRQ_MASK: rd_mux = irq_mask_r;
      default:      rd_mux = RST_BYTE;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rdata_r <= RST_BYTE;
    end else begin
      rdata_r <= bus.rd ? rd_mux : RST_BYTE;
    end
  end

  logic [NUM_PINS-1:0] pin_read_r;
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pin_read_r <= '0;
    end else begin
      pin_read_r <= pin_s2_r & ~dis_vec;
    end
  end

  assign BUS_RDATA       = rdata_r;
  assign PIN_READ        = pin_read_r;
  assign PIN_BUF_DISABLE = dis_vec;
  assign CONV_START      = start_r;
  assign CONV_BUSY       = (state_r == ST_CONV);
  assign CORE_CFG        = cfg_live;
  assign CONV_DONE_IRQ   = done_flag_r;
  assign IRQ             = |(irq_stat_r & irq_mask_r);
endmodule

/* File: dv/actc_chk.sv */
`timescale 1ns/1ps
module actc_chk
  import actc_pkg::*;
(
  input wire logic                         SYS_CLK,
  input wire logic                         SYS_RST,
  input wire logic [actc_pkg::ADDR_W-1:0]  BUS_ADDR,
  input wire logic                         BUS_RD,
  input wire logic [7:0]                   BUS_RDATA,
  input wire logic                         CONV_DONE,
  input wire logic                         DONE_VECTOR_ACK,
  input wire logic [actc_pkg::NUM_PINS-1:0] PIN_READ,
  input wire logic [actc_pkg::NUM_PINS-1:0] PIN_BUF_DISABLE,
  input wire logic                         CONV_START,
  input wire logic                         CONV_BUSY,
  input wire actc_pkg::actc_core_cfg_type  CORE_CFG,
  input wire logic                         CONV_DONE_IRQ
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  a_rsvd_zero:
  assert property (BUS_RD && BUS_ADDR == OFS_CTRL_B |=> !BUS_RDATA[5])
    else $error("reserved bit set");
  // Read lags the disable by one register stage
  a_pin_gate:
  assert property ((PIN_READ & PIN_BUF_DISABLE & $past(PIN_BUF_DISABLE)) == '0)
    else $error("disabled pin reads one");
  a_start_once:
  assert property (CONV_START |=> !CONV_START) else $error("long start");
  a_start_busy:
  assert property (CONV_START |-> CONV_BUSY) else $error("start not busy");
  a_done_flag:
  assert property (CONV_DONE && CONV_BUSY |=> CONV_DONE_IRQ)
    else $error("done flag missed");
  a_vec_clear:
  assert property (DONE_VECTOR_ACK && !CONV_DONE |=> !CONV_DONE_IRQ)
    else $error("done flag kept");
  a_busy_end:
  assert property (CONV_DONE && CONV_BUSY |=> !CONV_BUSY || CONV_START)
    else $error("busy kept");
  // Busy in two cycles running means no done and no idle update between
  a_msb_hold:
  assert property (CONV_BUSY && $past(CONV_BUSY)
    |-> $stable(CORE_CFG.channel_select_msb)) else $error("msb moved");
endmodule
bind actc_top actc_chk u_chk (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
  .BUS_ADDR(BUS_ADDR), .BUS_RD(BUS_RD), .BUS_RDATA(BUS_RDATA),
  .CONV_DONE(CONV_DONE), .DONE_VECTOR_ACK(DONE_VECTOR_ACK),
  .PIN_READ(PIN_READ), .PIN_BUF_DISABLE(PIN_BUF_DISABLE),
  .CONV_START(CONV_START), .CONV_BUSY(CONV_BUSY), .CORE_CFG(CORE_CFG),
  .CONV_DONE_IRQ(CONV_DONE_IRQ));

/* File: dv/actc_core_model.sv */
`timescale 1ns/1ps
module actc_core_model (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       start,
  input wire logic [3:0] lat,
  output logic           done
);
  logic [3:0] cnt_r;
  logic       run_r;
  // Latency is set per start so the bench can be prompt or slow
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 4'h0;
      run_r <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        run_r <= 1'b1;
        cnt_r <= lat;
      end else if (run_r && cnt_r == 4'h0) begin
        run_r <= 1'b0;
        done  <= 1'b1;
      end else if (run_r) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
endmodule

/* File: dv/actc_top_test.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  err_count++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
module actc_top_test;
  import actc_pkg::*;
  typedef struct {logic [3:0] a; logic [7:0] w; logic [7:0] e;} actc_row_type;
  logic                clk, rst, wr, rd, dvack, start, busy, done, dirq, irq;
  logic [ADDR_W-1:0]   addr;
  logic [7:0]          wdata, rdata, flags, v;
  logic [NUM_PINS-1:0] praw, pread, pdis;
  logic [3:0]          lat;
  actc_core_cfg_type   cfg;
  int                  err_count, tests_run, c;
  actc_row_type rows[5] = '{'{OFS_DIS_LOW, 8'hFF, 8'hFF},
    '{OFS_DIS_HIGH, 8'hFF, 8'hF0}, '{OFS_IRQ_MASK, 8'h03, 8'h03},
    '{4'hF, 8'hFF, 8'h00}, '{OFS_CTRL_B, 8'hFF, 8'hDF}};
  actc_top u_dut (.SYS_CLK(clk), .SYS_RST(rst), .BUS_ADDR(addr),
    .BUS_WDATA(wdata), .BUS_WR(wr), .BUS_RD(rd), .BUS_RDATA(rdata),
    .TRIG_FLAGS(flags), .CONV_DONE(done), .DONE_VECTOR_ACK(dvack),
    .PIN_RAW(praw), .PIN_READ(pread), .PIN_BUF_DISABLE(pdis),
    .CONV_START(start), .CONV_BUSY(busy), .CORE_CFG(cfg),
    .CONV_DONE_IRQ(dirq), .IRQ(irq));
  actc_core_model u_core (.clk(clk), .rst(rst), .start(start), .lat(lat),
    .done(done));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task final_report;
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [3:0] a);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task starts(input int cyc);
    c = 0;
    repeat (cyc) begin
      @(negedge clk);
      if (start === 1'b1) c++;
    end
  endtask
  task idle;
    c = 0;
    while (busy !== 1'b0 && c < 40) begin
      @(negedge clk);
      c++;
    end
    if (busy !== 1'b0) begin
      err_count++;
      final_report;
    end
  endtask
  initial begin
    rst = 1'b1; wr = 1'b0; rd = 1'b0; dvack = 1'b0; addr = '0; wdata = 8'h00;
    flags = 8'h00; praw = '1; lat = 4'h2; err_count = 0; tests_run = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_reg(OFS_DIS_LOW); `CHK("dis_low", 8'h00, v)
    rd_reg(OFS_CTRL_B); `CHK("ctrl_b", 8'h00, v)
    `CHK("cfg_rst", 4'h0, cfg[5:2])
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].w);
      rd_reg(rows[i].a);
      `CHK("reg", rows[i].e, v)
    end
    `CHK("cfg", 4'hF, cfg[5:2])
    `CHK("gain", 2'h1, cfg[1:0])
    wr_reg(OFS_DIS_LOW, 8'h29);
    wr_reg(OFS_DIS_HIGH, 8'h10);
    repeat (4) @(negedge clk);
    `CHK("pin_dis", 12'h191, pdis)
    `CHK("pin_read", 12'hE6E, pread)
    wr_reg(OFS_CTRL_B, 8'h01);
    wr_reg(OFS_CTRL_A, 8'h80);
    flags <= 8'h02;
    starts(10); `CHK("start_off", 0, c)
    @(posedge clk);
    flags <= 8'h00;
    repeat (4) @(posedge clk);
    wr_reg(OFS_CTRL_A, 8'hA0);
    for (int k = 1; k < 8; k++) begin
      @(posedge clk);
      flags <= 8'h00;
      wr_reg(OFS_CTRL_B, 8'(k));
      repeat (4) @(posedge clk);
      flags <= 8'h01 << k;
      starts(10); `CHK("start_src", 1, c)
      idle;
    end
    `CHK("irq", 1'b1, irq)
    rd_reg(OFS_CTRL_A); `CHK("ctrl_a", 8'hB0, v)
    wr_reg(OFS_CTRL_A, 8'hB0);
    rd_reg(OFS_CTRL_A); `CHK("ctrl_a_clr", 8'hA0, v)
    wr_reg(OFS_IRQ_STAT, 8'h03);
    @(negedge clk); `CHK("irq_clr", 1'b0, irq)
    wr_reg(OFS_IRQ_MASK, 8'h00);
    flags <= 8'h04;
    wr_reg(OFS_CTRL_B, 8'h01);
    repeat (4) @(posedge clk);
    lat <= 4'hC;
    // Source 2 flag is already high, so only the switch can start it
    wr_reg(OFS_CTRL_B, 8'h02);
    starts(4); `CHK("start_sw", 1, c)
    wr_reg(OFS_CTRL_B, 8'h0A);
    @(negedge clk); `CHK("msb_hold", 1'b0, cfg.channel_select_msb)
    idle;
    @(negedge clk); `CHK("msb_new", 1'b1, cfg.channel_select_msb)
    `CHK("irq_mask", 1'b0, irq)
    // Bit 0 high and done flag set: code zero must still not trigger
    @(posedge clk);
    flags <= 8'h05;
    wr_reg(OFS_CTRL_B, 8'h00);
    starts(8); `CHK("start_free", 0, c)
    @(posedge clk);
    dvack <= 1'b1;
    @(posedge clk);
    dvack <= 1'b0;
    @(negedge clk); `CHK("done_ack", 1'b0, dirq)
    // Reset while idle with live settings must bring all back to zero
    wr_reg(OFS_CTRL_B, 8'hC8);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK("pin_dis_rst", 12'h000, pdis)
    `CHK("cfg_rst2", 4'h0, cfg[5:2])
    rd_reg(OFS_DIS_LOW); `CHK("dis_low_rst", 8'h00, v)
    rd_reg(OFS_CTRL_B); `CHK("ctrl_b_rst", 8'h00, v)
    final_report;
  end
endmodule
